// file: rtl/fes_map.svh
// Purpose: Command codes, status bits and timing counts
// Assumes: 100 MHz system clock
// Notes:   Commands decode the low 16 address bits
`ifndef FES_MAP_SVH
`define FES_MAP_SVH
`define FES_CLK_MHZ      100
`define FES_UNLK1_A      16'h0555
`define FES_UNLK1_D      16'h00AA
`define FES_UNLK2_A      16'h02AA
`define FES_UNLK2_D      16'h0055
`define FES_CMD_PROG     16'h00A0
`define FES_CMD_ERASE    16'h0080
`define FES_CMD_SECT     16'h0030
`define FES_CMD_CHIP     16'h0010
`define FES_CMD_WBUF     16'h0025
`define FES_CMD_WCONF    16'h0029
`define FES_CMD_BYP      16'h0020
`define FES_CMD_BYPX1    16'h0090
`define FES_CMD_BYPX2    16'h0000
`define FES_CMD_PROT     16'h0060
`define FES_CMD_RST      16'h00F0
`define FES_PREPROG_D    16'h0000
`define FES_ERASED_D     16'hFFFF
`define FES_POLL_BIT     7
`define FES_TOG_BIT      6
`define FES_TOG2_BIT     2
`define FES_WB_WORDS     32
`define FES_WRAP8_MASK   23'h000007
`define FES_WRAP16_MASK  23'h00000F
`define FES_BND_MASK     7'h7F
`define FES_NOWAIT_MHZ   66
`define FES_BND_WAIT     2
`define FES_T_TOG_US     20
`define FES_TOG_CYC      (`FES_T_TOG_US * `FES_CLK_MHZ)
`define FES_T_WPROG_US   170
`define FES_T_SERASE_MS  800
`endif

// file: rtl/fes_pkg.sv
// Purpose: Types shared by the flash sequencer
// Assumes: 23-bit word address, 16-bit data
// Notes:   Enum codes are Gray along the usual path
package fes_pkg;
    typedef struct packed {
        logic [22:0] addr;
        logic [15:0] data;
    } fes_word_t;

    typedef enum logic [3:0] {
        C_IDLE = 4'h0, C_U1  = 4'h1, C_U2  = 4'h3, C_PROG = 4'h2,
        C_ER1  = 4'h6, C_ER2 = 4'h7, C_ER3 = 4'h5, C_WBC  = 4'h4,
        C_WBL  = 4'hC, C_WBF = 4'hD, C_BYP = 4'hF, C_BPG  = 4'hE,
        C_BX   = 4'hA, C_PROT = 4'hB
    } fes_cmd_t;

    typedef enum logic [2:0] {
        E_IDLE = 3'h0, E_PROG = 3'h1, E_PRE = 3'h3, E_ERS = 3'h2,
        E_FIL  = 3'h6, E_HOLD = 3'h7
    } fes_eng_t;

    typedef enum logic [1:0] {
        G_PROG = 2'h0, G_ERASE = 2'h1, G_PROT = 2'h3
    } fes_go_t;
endpackage

// file: rtl/fes_top.sv
// Purpose: Flash command sequencer, embedded op engine and burst reads
// Assumes: Host strobes and burst clock are asynchronous, two-flop synced
// Notes:   Small flop array; four banks of one sector
// Overview of operation
// - Embedded-op status comes from asynchronous reads, not bursts
// - Toggle bits freeze after completion
// - After completion, polled reads return stored data
// - Wrapped burst restarts at its 8 or 16 group start
// - Each 128-word boundary and address zero may stall bursts
// - No boundary wait at burst clocks up to 66 MHz
// - Boundary waits drive ready low; host waits for ready
// - Command cycles decode only address bits below A16
// - Erase first programs every unprotected target word to zero
// - Other banks stay readable while one is busy
// - Reads and writes follow each other with no gap
// - Up to 32 words buffered, programmed as one operation
// - Program to protected sector toggles 20 us, data kept, unless the last erase command was a chip erase
// - Sector protection toggles status 20 us, then completes
`include "fes_map.svh"

module fes_fifo #(
    parameter int W     = 39,
    parameter int DEPTH = 16
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         clr_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0] mem_r [DEPTH];
    logic [PW:0]  wp_r;
    logic [PW:0]  rp_r;

    assign out_valid_o = (wp_r != rp_r);
    assign in_ready_o  = (wp_r != {~rp_r[PW], rp_r[PW-1:0]});
    assign out_data_o  = mem_r[rp_r[PW-1:0]];

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wp_r <= '0;
            rp_r <= '0;
        end else if (clr_i) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (in_valid_i && in_ready_o) begin
                wp_r <= wp_r + 1'b1;
            end
            if (out_valid_o && out_ready_i) begin
                rp_r <= rp_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (in_valid_i && in_ready_o) begin
            mem_r[wp_r[PW-1:0]] <= in_data_i;
        end
    end
endmodule

module fes_top import fes_pkg::*; #(
    parameter int          MEM_WORDS = 256,
    parameter int          BCLK_MHZ  = 108,
    parameter int          FIFO_DEPTH = 16,
    parameter int unsigned PROG_CYC  = `FES_T_WPROG_US * `FES_CLK_MHZ,
    parameter int unsigned ERASE_CYC = `FES_T_SERASE_MS * 1000 * `FES_CLK_MHZ
) (
    input  wire logic        SYS_CLK_I,
    input  wire logic        RESET_N_I,
    input  wire logic        CE_N_I,
    input  wire logic        ADDRESS_VALID_STROBE_N_I,
    input  wire logic        WE_N_I,
    input  wire logic        OE_N_I,
    input  wire logic        BURST_CLK_I,
    input  wire logic        SYNC_READ_I,
    input  wire logic [1:0]  WRAP_MODE_I,
    input  wire logic [6:0]  A_HI_I,
    input  wire logic [15:0] ADQ_I,
    output logic      [15:0] ADQ_O,
    output logic             ADQ_OE_O,
    output logic             RDY_O
);
    localparam int AW = $clog2(MEM_WORDS);
    localparam int SW = 31;

    logic rst1_r, rst_n;
    logic [SW-1:0] s1_r, s2_r, p_r;
    logic ce_n, adv_n, we_n, oe_n, bclk, sync_rd;
    logic [1:0] wrap;
    logic [15:0] adq;
    logic we_rise, oe_fall, bclk_rise;
    logic [22:0] addr_r;
    fes_cmd_t cst_r;
    logic byp_r;
    logic go_r, go_chip_r;
    fes_go_t go_kind_r;
    logic [22:0] go_addr_r;
    logic [15:0] wb_dat_r [`FES_WB_WORDS];
    logic [4:0]  wb_off_r [`FES_WB_WORDS];
    logic [4:0]  wb_i_r, wb_last_r;
    fes_eng_t est_r;
    logic [31:0] cnt_r;
    logic [AW-1:0] ei_r, eend_r, ebase_r;
    logic [4:0] pi_r;
    logic [3:0] busy_r, prot_r;
    logic poll_r, ers_r, tog_r;
    logic [15:0] mem_r [MEM_WORDS];
    logic [15:0] dout_r;
    logic brun_r, rdy_r, last_bnd_r;
    logic [1:0] bwrap_r;
    logic [22:0] fa_r;
    logic [1:0] wcnt_r;
    logic f_irdy, f_ov, pop, stall, rd_busy;
    fes_word_t f_in, f_out;

    function automatic logic [1:0] bank_of(input logic [AW-1:0] i);
        return i[AW-1 -: 2];
    endfunction

    function automatic logic [22:0] nxt(input logic [22:0] a, input logic [1:0] m);
        logic [22:0] k;
        k = (m == 2'd1) ? `FES_WRAP8_MASK : (m == 2'd2) ? `FES_WRAP16_MASK : 23'h7FFFFF;
        return (a & ~k) | ((a + 23'h000001) & k);
    endfunction

    // Reset release and pin synchronisers
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rst1_r <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst1_r <= 1'b1;
            rst_n  <= rst1_r;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '1;
            s2_r <= '1;
            p_r  <= '1;
        end else begin
            s1_r <= {CE_N_I, ADDRESS_VALID_STROBE_N_I, WE_N_I, OE_N_I, BURST_CLK_I,
                     SYNC_READ_I, WRAP_MODE_I, A_HI_I, ADQ_I};
            s2_r <= s1_r;
            p_r  <= s2_r;
        end
    end

    assign {ce_n, adv_n, we_n, oe_n, bclk, sync_rd, wrap} = s2_r[30:23];
    assign adq       = s2_r[15:0];
    assign we_rise   = we_n && !p_r[28] && !ce_n;
    assign oe_fall   = !oe_n && p_r[27] && !ce_n;
    assign bclk_rise = bclk && !p_r[26];
    assign rd_busy   = busy_r[bank_of(addr_r[AW-1:0])];

    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            addr_r <= '0;
        end else if (!ce_n && !adv_n) begin
            addr_r <= s2_r[22:0];
        end
    end

    // Command sequencer; writes right after reads are taken
    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            cst_r <= C_IDLE;
            byp_r <= 1'b0;
            go_r <= 1'b0;
            go_chip_r <= 1'b0;
            go_kind_r <= G_PROG;
            go_addr_r <= '0;
            wb_i_r <= '0;
            wb_last_r <= '0;
        end else begin
            go_r <= 1'b0;
            if (we_rise && est_r == E_IDLE && !go_r) begin
                // Only A15..A0 take part in decode
                unique case (cst_r)
                    C_IDLE: cst_r <= (addr_r[15:0] == `FES_UNLK1_A && adq == `FES_UNLK1_D)
                                     ? C_U1 : C_IDLE;
                    C_U1:   cst_r <= (addr_r[15:0] == `FES_UNLK2_A && adq == `FES_UNLK2_D)
                                     ? C_U2 : C_IDLE;
                    C_U2: begin
                        go_addr_r <= addr_r;
                        unique case (adq)
                            `FES_CMD_PROG:  cst_r <= C_PROG;
                            `FES_CMD_ERASE: cst_r <= C_ER1;
                            `FES_CMD_WBUF:  cst_r <= C_WBC;
                            `FES_CMD_BYP: begin
                                byp_r <= 1'b1;
                                cst_r <= C_BYP;
                            end
                            `FES_CMD_PROT:  cst_r <= C_PROT;
                            default:        cst_r <= C_IDLE;
                        endcase
                    end
                    C_PROG, C_BPG: begin
                        // Four- and two-write program forms
                        wb_dat_r[0] <= adq;
                        wb_off_r[0] <= addr_r[4:0];
                        wb_last_r <= '0;
                        go_addr_r <= addr_r;
                        go_kind_r <= G_PROG;
                        go_r <= 1'b1;
                        cst_r <= byp_r ? C_BYP : C_IDLE;
                    end
                    C_ER1:  cst_r <= (addr_r[15:0] == `FES_UNLK1_A && adq == `FES_UNLK1_D)
                                     ? C_ER2 : C_IDLE;
                    C_ER2:  cst_r <= (addr_r[15:0] == `FES_UNLK2_A && adq == `FES_UNLK2_D)
                                     ? C_ER3 : C_IDLE;
                    C_ER3: begin
                        go_kind_r <= G_ERASE;
                        go_addr_r <= addr_r;
                        go_chip_r <= (adq == `FES_CMD_CHIP);
                        go_r <= (adq == `FES_CMD_SECT) || (adq == `FES_CMD_CHIP);
                        cst_r <= C_IDLE;
                    end
                    C_WBC: begin
                        wb_last_r <= adq[4:0];
                        wb_i_r <= '0;
                        cst_r <= C_WBL;
                    end
                    C_WBL: begin
                        // Load up to 32 words
                        wb_dat_r[wb_i_r] <= adq;
                        wb_off_r[wb_i_r] <= addr_r[4:0];
                        wb_i_r <= wb_i_r + 5'h01;
                        cst_r <= (wb_i_r == wb_last_r) ? C_WBF : C_WBL;
                    end
                    C_WBF: begin
                        go_kind_r <= G_PROG;
                        go_r <= (adq == `FES_CMD_WCONF);
                        cst_r <= C_IDLE;
                    end
                    C_BYP:  cst_r <= (adq == `FES_CMD_PROG) ? C_BPG :
                                     (adq == `FES_CMD_BYPX1) ? C_BX : C_BYP;
                    C_BX: begin
                        byp_r <= (adq != `FES_CMD_BYPX2);
                        cst_r <= (adq == `FES_CMD_BYPX2) ? C_IDLE : C_BYP;
                    end
                    C_PROT: begin
                        go_kind_r <= G_PROT;
                        go_addr_r <= addr_r;
                        go_r <= 1'b1;
                        cst_r <= C_IDLE;
                    end
                endcase
                if (adq == `FES_CMD_RST && !byp_r) begin
                    cst_r <= C_IDLE;
                end
            end
        end
    end

    // Embedded program / erase engine
    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            est_r <= E_IDLE;
            cnt_r <= '0;
            ei_r <= '0;
            eend_r <= '0;
            ebase_r <= '0;
            pi_r <= '0;
            busy_r <= '0;
            prot_r <= '0;
            poll_r <= 1'b0;
            ers_r <= 1'b0;
            for (int i = 0; i < MEM_WORDS; i++) begin
                mem_r[i] <= `FES_ERASED_D;
            end
        end else begin
            unique case (est_r)
                E_IDLE: if (go_r) begin
                    ebase_r <= go_addr_r[AW-1:0];
                    busy_r <= go_chip_r && go_kind_r == G_ERASE ? 4'hF
                              : 4'h1 << bank_of(go_addr_r[AW-1:0]);
                    pi_r <= '0;
                    ers_r <= (go_kind_r == G_ERASE);
                    // Busy poll bit is complemented data
                    poll_r <= (go_kind_r == G_ERASE) ? 1'b0
                              : ~wb_dat_r[wb_last_r][`FES_POLL_BIT];
                    if (go_kind_r == G_PROT ||
                        (!go_chip_r && prot_r[bank_of(go_addr_r[AW-1:0])])) begin
                        // Protect, or target protected
                        if (go_kind_r == G_PROT) begin
                            prot_r[bank_of(go_addr_r[AW-1:0])] <= 1'b1;
                        end
                        cnt_r <= `FES_TOG_CYC - 1;
                        est_r <= E_HOLD;
                    end else if (go_kind_r == G_PROG) begin
                        cnt_r <= PROG_CYC - 1;
                        est_r <= E_PROG;
                    end else begin
                        ei_r <= go_chip_r ? '0 : {go_addr_r[AW-1 -: 2], {(AW-2){1'b0}}};
                        eend_r <= go_chip_r ? '1 : {go_addr_r[AW-1 -: 2], {(AW-2){1'b1}}};
                        est_r <= E_PRE;
                    end
                end
                E_PROG: if (cnt_r != 0) begin
                    cnt_r <= cnt_r - 1;
                end else begin
                    mem_r[{ebase_r[AW-1:5], wb_off_r[pi_r]}] <= wb_dat_r[pi_r];
                    pi_r <= pi_r + 5'h01;
                    cnt_r <= PROG_CYC - 1;
                    if (pi_r == wb_last_r) begin
                        est_r <= E_IDLE;
                        busy_r <= '0;
                    end
                end
                E_PRE: begin
                    // Pre-program each unprotected target word to zero
                    if (!prot_r[bank_of(ei_r)]) begin
                        mem_r[ei_r] <= `FES_PREPROG_D;
                    end
                    if (ei_r == eend_r) begin
                        ei_r <= {eend_r[AW-1 -: 2], {(AW-2){1'b0}}} & (busy_r == 4'hF ? '0 : '1);
                        cnt_r <= ERASE_CYC - 1;
                        est_r <= E_ERS;
                    end else begin
                        ei_r <= ei_r + 1'b1;
                    end
                end
                E_ERS: if (cnt_r != 0) begin
                    cnt_r <= cnt_r - 1;
                end else begin
                    est_r <= E_FIL;
                end
                E_FIL: begin
                    if (!prot_r[bank_of(ei_r)]) begin
                        mem_r[ei_r] <= `FES_ERASED_D;
                    end
                    ei_r <= ei_r + 1'b1;
                    if (ei_r == eend_r) begin
                        est_r <= E_IDLE;
                        busy_r <= '0;
                    end
                end
                E_HOLD: if (cnt_r != 0) begin
                    cnt_r <= cnt_r - 1;
                end else begin
                    est_r <= E_IDLE;
                    busy_r <= '0;
                end
                default: est_r <= E_IDLE;
            endcase
        end
    end

    // Burst prefetch FIFO, drained on burst clock rises
    assign f_in.addr = fa_r;
    assign f_in.data = mem_r[fa_r[AW-1:0]];
    // Boundary wait only above the no-wait limit
    assign stall = last_bnd_r && (BCLK_MHZ > `FES_NOWAIT_MHZ);
    assign pop   = brun_r && bclk_rise && f_ov && wcnt_r == 2'd0 && !stall;

    fes_fifo #(.W($bits(fes_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i       (SYS_CLK_I),
        .rst_n_i     (rst_n),
        .clr_i       (!brun_r),
        .in_valid_i  (brun_r),
        .in_ready_o  (f_irdy),
        .in_data_i   (f_in),
        .out_valid_o (f_ov),
        .out_ready_i (pop),
        .out_data_o  (f_out)
    );

    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            brun_r <= 1'b0;
            bwrap_r <= '0;
            fa_r <= '0;
            rdy_r <= 1'b0;
            last_bnd_r <= 1'b0;
            wcnt_r <= '0;
            dout_r <= '0;
            tog_r <= 1'b0;
        end else begin
            if (ce_n || oe_n) begin
                brun_r <= 1'b0;
            end else if (oe_fall) begin
                // Bursts only from idle banks; busy banks answer status
                if (sync_rd && !rd_busy) begin
                    brun_r <= 1'b1;
                    fa_r <= addr_r;
                    bwrap_r <= wrap;
                    rdy_r <= 1'b0;
                    last_bnd_r <= 1'b0;
                    wcnt_r <= '0;
                end else if (rd_busy) begin
                    // Status word; frozen and true data once idle
                    dout_r <= '0;
                    dout_r[`FES_POLL_BIT] <= poll_r;
                    dout_r[`FES_TOG_BIT] <= tog_r;
                    dout_r[`FES_TOG2_BIT] <= ers_r & tog_r;
                    tog_r <= ~tog_r;
                end else begin
                    dout_r <= mem_r[addr_r[AW-1:0]];
                end
            end
            if (brun_r && f_irdy) begin
                fa_r <= nxt(fa_r, bwrap_r);
            end
            if (brun_r && bclk_rise) begin
                // Ready low while waiting or starved
                rdy_r <= pop;
                if (stall) begin
                    wcnt_r <= 2'(`FES_BND_WAIT - 1);
                    last_bnd_r <= 1'b0;
                end else if (wcnt_r != 2'd0) begin
                    wcnt_r <= wcnt_r - 2'd1;
                end
            end
            if (pop) begin
                dout_r <= f_out.data;
                last_bnd_r <= (f_out.addr[6:0] == `FES_BND_MASK) || (f_out.addr == 23'h000000);
            end
        end
    end

    assign ADQ_O    = dout_r;
    assign ADQ_OE_O = !ce_n && !oe_n && we_n;
    assign RDY_O    = brun_r ? rdy_r : 1'b1;
endmodule

// file: test/fes_host.sv
// Purpose: Host controller model driving the multiplexed bus
// Assumes: Strobes change just after a clock rise
// Notes:   A released bus carries the inverse of its last value
module fes_host (
    input  wire logic        clk_i,
    input  wire logic [15:0] adq_i,
    input  wire logic        rdy_i,
    output logic             ce_n_o,
    output logic             avs_n_o,
    output logic             we_n_o,
    output logic             oe_n_o,
    output logic             bclk_o,
    output logic [6:0]       a_hi_o,
    output logic [15:0]      adq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {ce_n_o, avs_n_o, we_n_o, oe_n_o, bclk_o} = 5'h1E;
        a_hi_o = 7'h00;
        adq_o = 16'h0000;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic adr(input logic [22:0] a);
        ce_n_o  <= 1'b0;
        avs_n_o <= 1'b0;
        a_hi_o  <= a[22:16];
        adq_o   <= a[15:0];
        tick(3);
        avs_n_o <= 1'b1;
        adq_o   <= ~a[15:0];
        tick(3);
    endtask
    task automatic wr(input logic [22:0] a, input logic [15:0] d);
        adr(a);
        adq_o  <= d;
        we_n_o <= 1'b0;
        tick(4);
        we_n_o <= 1'b1;
        tick(4);
        adq_o  <= ~d;
        ce_n_o <= 1'b1;
        tick(3);
    endtask
    task automatic rd(input logic [22:0] a, output logic [15:0] d);
        adr(a);
        oe_n_o <= 1'b0;
        tick(6);
        @(negedge clk_i);
        d = adq_i;
        @(posedge clk_i);
        oe_n_o <= 1'b1;
        ce_n_o <= 1'b1;
        tick(3);
    endtask
    task automatic burst(input logic [22:0] a, input int n,
                         output logic [15:0] w [16], output int g [16]);
        int k, r;
        logic got;
        adr(a);
        oe_n_o <= 1'b0;
        for (k = 0; k < n; k++) begin
            g[k] = 0;
            w[k] = 16'h0000;
            got  = 1'b0;
            for (r = 0; r < 40 && !got; r++) begin
                bclk_o <= 1'b1;
                tick(5);
                @(negedge clk_i);
                got  = rdy_i;
                w[k] = got ? adq_i : w[k];
                g[k] = got ? g[k] : g[k] + 1;
                @(posedge clk_i);
                bclk_o <= 1'b0;
                tick(4);
            end
        end
        oe_n_o <= 1'b1;
        ce_n_o <= 1'b1;
        tick(3);
    endtask
endmodule

// file: test/fes_top_chk.sv
// Purpose: Port checks of the flash sequencer
// Assumes: Pins pass two-flop synchronisers
// Notes:   Attached by bind
module fes_top_chk (
    input wire logic        SYS_CLK_I,
    input wire logic        RESET_N_I,
    input wire logic        CE_N_I,
    input wire logic        WE_N_I,
    input wire logic        OE_N_I,
    input wire logic        BURST_CLK_I,
    input wire logic        SYNC_READ_I,
    input wire logic [15:0] ADQ_O,
    input wire logic        ADQ_OE_O,
    input wire logic        RDY_O
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] low_cnt_r;
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            low_cnt_r <= 8'h00;
        end else begin
            low_cnt_r <= RDY_O ? 8'h00 : low_cnt_r + 8'h01;
        end
    end
    sequence s_write;
        !WE_N_I [*3];
    endsequence
    sequence s_no_oe;
        OE_N_I [*4];
    endsequence
    sequence s_async;
        !SYNC_READ_I [*4];
    endsequence
    sequence s_quiet;
        (ADQ_OE_O && $stable(BURST_CLK_I)) [*6];
    endsequence
    rst_quiet_a: assert property ($rose(RESET_N_I) |-> !ADQ_OE_O && RDY_O)
        else $error("outputs active out of reset");
    drive_follow_a:
        assert property ($past(RESET_N_I, 4) |->
            ADQ_OE_O == $past(!CE_N_I && !OE_N_I && WE_N_I, 2))
        else $error("bus drive does not follow strobes");
    write_quiet_a: assert property (s_write |-> !ADQ_OE_O)
        else $error("bus driven during write");
    async_ready_a: assert property (s_async |-> RDY_O)
        else $error("ready low in async mode");
    idle_ready_a: assert property (s_no_oe |-> RDY_O)
        else $error("ready low with output disabled");
    ready_cause_a: assert property (!RDY_O |-> ADQ_OE_O || $past(ADQ_OE_O))
        else $error("ready low outside a read");
    stall_bound_a: assert property (low_cnt_r < 8'h64)
        else $error("ready held low too long");
    data_hold_a: assert property (s_quiet |-> $stable(ADQ_O))
        else $error("data changed without a pop");
endmodule
bind fes_top fes_top_chk fes_top_chk_i (.SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I),
    .CE_N_I(CE_N_I), .WE_N_I(WE_N_I), .OE_N_I(OE_N_I), .BURST_CLK_I(BURST_CLK_I),
    .SYNC_READ_I(SYNC_READ_I), .ADQ_O(ADQ_O), .ADQ_OE_O(ADQ_OE_O), .RDY_O(RDY_O));

// file: test/fes_top_tb.sv
// Purpose: Self-checking bench for the flash sequencer
// Assumes: Short program and erase counts
// Notes:   Host model drives the bus
`include "fes_map.svh"
module fes_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PC = 200;
    localparam int EC = 300;
    localparam int TC = `FES_TOG_CYC;
    localparam logic [22:0] U1 = {7'h7F, `FES_UNLK1_A};
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        sync_rd = 1'b0;
    logic [1:0]  wrap = 2'h0;
    logic        ce_n, avs_n, we_n, oe_n, bclk, adq_oe, rdy;
    logic [6:0]  a_hi;
    logic [15:0] adq_h, adq_d, bus;
    int          cyc = 0;
    int          mismatches = 0;
    int          n_checks = 0;
    assign bus = adq_oe ? adq_d : adq_h;
    always #5 clk = ~clk;
    fes_host h (.clk_i(clk), .adq_i(bus), .rdy_i(rdy), .ce_n_o(ce_n), .avs_n_o(avs_n),
        .we_n_o(we_n), .oe_n_o(oe_n), .bclk_o(bclk), .a_hi_o(a_hi), .adq_o(adq_h));
    fes_top #(.PROG_CYC(PC), .ERASE_CYC(EC)) fes_top_i (.SYS_CLK_I(clk), .RESET_N_I(rst_n),
        .CE_N_I(ce_n), .ADDRESS_VALID_STROBE_N_I(avs_n), .WE_N_I(we_n), .OE_N_I(oe_n),
        .BURST_CLK_I(bclk), .SYNC_READ_I(sync_rd), .WRAP_MODE_I(wrap), .A_HI_I(a_hi),
        .ADQ_I(bus), .ADQ_O(adq_d), .ADQ_OE_O(adq_oe), .RDY_O(rdy));
    task automatic tally_and_finish();
        if (mismatches == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rng(input int t, lo, hi);
        cmp(16'(t >= lo && t <= hi), 16'h0001);
    endtask
    task automatic unl();
        h.wr(U1, `FES_UNLK1_D);
        h.wr({7'h7F, `FES_UNLK2_A}, `FES_UNLK2_D);
    endtask
    task automatic poll(input logic [22:0] a);
        logic [15:0] p, q;
        int k;
        h.rd(a, q);
        for (k = 0; k < 300; k++) begin
            p = q;
            h.rd(a, q);
            if (q === p) break;
        end
        cmp(q, p);
    endtask
    task automatic t_prog();
        logic [15:0] s0, s1;
        unl();
        h.wr(U1, `FES_CMD_PROG);
        h.wr(23'h3, 16'h5A3C);
        h.rd(23'h3, s0);
        h.rd(23'h3, s1);
        cmp(s0 & 16'hFFBF, 16'h0080);
        cmp(s0 ^ s1, 16'h0040);
        poll(23'h3);
        h.rd(23'h3, s0);
        cmp(s0, 16'h5A3C);
        unl();
        h.wr(U1, `FES_CMD_BYP);
        h.wr(23'h0, `FES_CMD_PROG);
        h.wr(23'h4, 16'hC3A5);
        poll(23'h4);
        h.wr(23'h0, `FES_CMD_BYPX1);
        h.wr(23'h0, `FES_CMD_BYPX2);
        h.rd(23'h4, s0);
        cmp(s0, 16'hC3A5);
    endtask
    task automatic t_buf();
        int k;
        unl();
        h.wr(23'h70, `FES_CMD_WBUF);
        h.wr(23'h70, 16'h000F);
        for (k = 0; k < 16; k++) h.wr(23'(8'h70 + k), 16'(16'hB070 + k));
        h.wr(23'h70, `FES_CMD_WCONF);
        poll(23'h70);
    endtask
    function automatic logic [15:0] exp_d(input logic [22:0] x);
        return x[22:4] == 19'h7 ? {12'hB07, x[3:0]} :
            x == 23'h3 ? 16'h5A3C : x == 23'h4 ? 16'hC3A5 : `FES_ERASED_D;
    endfunction
    task automatic t_burst(input logic [22:0] a, input logic [1:0] m, input int n);
        logic [15:0] w [16];
        int          g [16];
        logic [22:0] x, p;
        int          k;
        sync_rd <= 1'b1;
        wrap    <= m;
        h.burst(a, n, w, g);
        x = a;
        p = a;
        for (k = 0; k < n; k++) begin
            cmp(w[k], exp_d(x));
            if (k > 0) cmp(16'(g[k]), (p[6:0] == 7'h7F || p == 23'h0) ? 16'h2 : 16'h0);
            p = x;
            x = m == 2'h1 ? {x[22:3], x[2:0] + 3'h1} :
                m == 2'h2 ? {x[22:4], x[3:0] + 4'h1} : x + 23'h1;
        end
        sync_rd <= 1'b0;
    endtask
    task automatic t_erase();
        logic [15:0] s0, s1, d;
        int t0;
        unl();
        h.wr(U1, `FES_CMD_ERASE);
        unl();
        h.wr(23'h40, `FES_CMD_SECT);
        t0 = cyc;
        h.rd(23'h40, s0);
        h.rd(23'h3, d);
        h.rd(23'h40, s1);
        cmp(d, 16'h5A3C);
        cmp(s0 & 16'hFFBB, 16'h0000);
        cmp(s0 ^ s1, 16'h0044);
        poll(23'h40);
        rng(cyc - t0, EC + 118, EC + 200);
        h.rd(23'h75, d);
        cmp(d, `FES_ERASED_D);
    endtask
    task automatic t_prot();
        logic [15:0] d;
        int t0;
        unl();
        h.wr(U1, `FES_CMD_PROT);
        h.wr(23'h80, `FES_CMD_PROT);
        t0 = cyc;
        poll(23'h80);
        rng(cyc - t0, TC - 10, TC + 80);
        unl();
        h.wr(U1, `FES_CMD_PROG);
        h.wr(23'h85, 16'h1234);
        t0 = cyc;
        poll(23'h85);
        rng(cyc - t0, TC - 10, TC + 80);
        h.rd(23'h85, d);
        cmp(d, `FES_ERASED_D);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        t_prog();
        t_buf();
        t_burst(23'h75, 2'h1, 9);
        t_burst(23'h7D, 2'h2, 6);
        t_burst(23'h7D, 2'h0, 5);
        t_burst(23'h00, 2'h3, 5);
        t_erase();
        t_prot();
        tally_and_finish();
    end
endmodule
